// ---- mai_pkg.sv ----
`default_nettype none
package mai_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_ACT_THR_H   = 8'h20;
    localparam logic [7:0] IDX_ACT_THR_L   = 8'h21;
    localparam logic [7:0] IDX_ACT_DUR     = 8'h22;
    localparam logic [7:0] IDX_INACT_THR_H = 8'h23;
    localparam logic [7:0] IDX_INACT_THR_L = 8'h24;
    localparam logic [7:0] IDX_INACT_DUR_H = 8'h25;
    localparam logic [7:0] IDX_INACT_DUR_L = 8'h26;
    localparam logic [7:0] IDX_STATUS      = 8'h30;
    localparam logic [7:0] IDX_MASK        = 8'h31;
    // Field layout
    localparam int THR_HI_W   = 7;
    localparam int THR_LO_W   = 6;
    localparam int THR_LO_POS = 2;
    localparam int AXIS_W     = 14;
    localparam int THR_W      = 13;
    localparam int NUM_AXES   = 3;
    localparam int ST_ACT_BIT   = 0;
    localparam int ST_INACT_BIT = 1;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_ST   = 2'h0;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;
endpackage : mai_pkg
`default_nettype wire

// ---- mai_top.sv ----
// Behaviour
// R1 - Activity event after activity_duration consecutive samples with some axis above threshold.
// R2 - Inactive sample needs every axis magnitude strictly below the 13-bit threshold.
// R3 - Inactivity threshold is high[6:0] as MSBs joined with low[7:2] as LSBs.
// R4 - Inactivity event after the programmed count of consecutive all-axes-quiet samples.
// R5 - Inactivity duration is high byte [15:8] joined with low byte [7:0].
// R6 - Reset clears activity duration, inactivity threshold and duration bytes to zero.
// R7 - Activity compares each signed axis magnitude against the 13-bit activity threshold.
// R8 - A failing sample restarts its counter; reserved bits read zero, ignore writes.
`timescale 1ns/1ps
`default_nettype none
module mai_top (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    // Sample stream from the data path
    input  wire logic                 sample_valid,
    input  wire logic signed [13:0]   sample_x,
    input  wire logic signed [13:0]   sample_y,
    input  wire logic signed [13:0]   sample_z,
    // Events and interrupt
    output logic                      activity_event,
    output logic                      inactivity_event,
    output logic                      irq
);
    // Register state
    logic [6:0]  act_thr_h_r;
    logic [5:0]  act_thr_l_r;
    logic [7:0]  act_dur_r;
    logic [6:0]  inact_thr_h_r;
    logic [5:0]  inact_thr_l_r;
    logic [7:0]  inact_dur_h_r;
    logic [7:0]  inact_dur_l_r;
    logic [1:0]  status_r;
    logic [1:0]  mask_r;
    logic [1:0]  status_nxt;
    logic [1:0]  mask_nxt;
    // Bus data phase state
    logic        wr_pend_r;
    logic [7:0]  wr_idx_r;
    // Detection counters
    logic [7:0]  act_cnt_r;
    logic [15:0] inact_cnt_r;
    logic [7:0]  act_cnt_nxt;
    logic [15:0] inact_cnt_nxt;

    // Address phase decode; only low ten address bits map
    wire         addr_ok   = hsel && hready && (htrans == mai_pkg::HTRANS_NONSEQ);
    wire         in_map    = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
    wire [7:0]   addr_idx  = haddr[9:2];
    wire         rd_start  = addr_ok && !hwrite;
    wire         wr_start  = addr_ok && hwrite && in_map;

    // Data phase write strobes, low byte lane carries the data
    wire [7:0]   wd        = hwdata[7:0];
    wire         we_act_h  = wr_pend_r && (wr_idx_r == mai_pkg::IDX_ACT_THR_H);
    wire         we_act_l  = wr_pend_r && (wr_idx_r == mai_pkg::IDX_ACT_THR_L);
    wire         we_adur   = wr_pend_r && (wr_idx_r == mai_pkg::IDX_ACT_DUR);
    wire         we_ith_h  = wr_pend_r && (wr_idx_r == mai_pkg::IDX_INACT_THR_H);
    wire         we_ith_l  = wr_pend_r && (wr_idx_r == mai_pkg::IDX_INACT_THR_L);
    wire         we_idur_h = wr_pend_r && (wr_idx_r == mai_pkg::IDX_INACT_DUR_H);
    wire         we_idur_l = wr_pend_r && (wr_idx_r == mai_pkg::IDX_INACT_DUR_L);
    wire         we_stat   = wr_pend_r && (wr_idx_r == mai_pkg::IDX_STATUS);
    wire         we_mask   = wr_pend_r && (wr_idx_r == mai_pkg::IDX_MASK);

    // Assembled thresholds and target counts
    wire [12:0]  act_thr      = {act_thr_h_r, act_thr_l_r};
    wire [12:0]  inact_thr    = {inact_thr_h_r, inact_thr_l_r};        // R3
    wire [15:0]  inact_dur    = {inact_dur_h_r, inact_dur_l_r};        // R5
    // A zero count behaves as one, so the first qualifying sample fires
    wire [7:0]   act_target   = (act_dur_r == 8'h00) ? 8'h01 : act_dur_r;
    wire [15:0]  inact_target = (inact_dur == 16'h0000) ? 16'h0001 : inact_dur;

    // Read mux; reserved bits come back as zero
    wire [7:0]   rd_byte =
        (addr_idx == mai_pkg::IDX_ACT_THR_H)   ? {1'b0, act_thr_h_r} :
        (addr_idx == mai_pkg::IDX_ACT_THR_L)   ? {act_thr_l_r, 2'b00} :
        (addr_idx == mai_pkg::IDX_ACT_DUR)     ? act_dur_r :
        (addr_idx == mai_pkg::IDX_INACT_THR_H) ? {1'b0, inact_thr_h_r} :   // R8
        (addr_idx == mai_pkg::IDX_INACT_THR_L) ? {inact_thr_l_r, 2'b00} :  // R8
        (addr_idx == mai_pkg::IDX_INACT_DUR_H) ? inact_dur_h_r :
        (addr_idx == mai_pkg::IDX_INACT_DUR_L) ? inact_dur_l_r :
        (addr_idx == mai_pkg::IDX_STATUS)      ? {6'h00, status_r} :
        (addr_idx == mai_pkg::IDX_MASK)        ? {6'h00, mask_r} : 8'h00;

    // Per-axis magnitude; -8192 gives 8192, which still fits 14 bits
    logic [2:0]  act_hit;
    logic [2:0]  inact_hit;
    wire  [41:0] axes = {sample_z, sample_y, sample_x};
    genvar g;
    generate
        for (g = 0; g < mai_pkg::NUM_AXES; g++) begin : g_axis
            wire [13:0] raw = axes[g*mai_pkg::AXIS_W +: mai_pkg::AXIS_W];
            wire [13:0] mag = raw[13] ? (14'h0000 - raw) : raw;
            assign act_hit[g]   = mag > {1'b0, act_thr};              // R7
            assign inact_hit[g] = mag < {1'b0, inact_thr};            // R2
        end
    endgenerate

    // Compare edges: negative full scale, a negative sample at the exact threshold and a zero threshold
    a_act_min_axis: assert property (@(posedge core_clk) disable iff (srst) // R7
        sample_valid && (sample_x == 14'sh2000) |=> act_cnt_r != 8'h00)
        else $error("negative full scale not counted as activity");
    a_inact_neg_equal: assert property (@(posedge core_clk) disable iff (srst) // R2
        sample_valid && (sample_y == -$signed({1'b0, inact_thr})) |=> inact_cnt_r == 16'h0000)
        else $error("negative sample at threshold counted inactive");
    a_inact_zero_thr: assert property (@(posedge core_clk) disable iff (srst) // R2
        sample_valid && (inact_thr == 13'h0000) |=> inact_cnt_r == 16'h0000)
        else $error("sample counted inactive below a zero threshold");

    wire         act_q   = |act_hit;                                  // R1
    wire         inact_q = &inact_hit;                                // R4
    wire         act_fire   = sample_valid && act_q && (act_cnt_r != act_target)
                              && ((act_cnt_r + 8'h01) == act_target);
    wire         inact_fire = sample_valid && inact_q && (inact_cnt_r != inact_target)
                              && ((inact_cnt_r + 16'h0001) == inact_target);

    // Counters saturate at the target so an event fires once per run
    always_comb begin
        act_cnt_nxt   = act_cnt_r;
        inact_cnt_nxt = inact_cnt_r;
        if (sample_valid) begin
            if (!act_q) begin
                act_cnt_nxt = 8'h00;                                  // R8
            end else if (act_cnt_r < act_target) begin
                act_cnt_nxt = act_cnt_r + 8'h01;                      // R1
            end else begin
                act_cnt_nxt = act_target;
            end
            if (!inact_q) begin
                inact_cnt_nxt = 16'h0000;                             // R8
            end else if (inact_cnt_r < inact_target) begin
                inact_cnt_nxt = inact_cnt_r + 16'h0001;               // R4
            end else begin
                inact_cnt_nxt = inact_target;
            end
        end
    end

    // Inactivity restart and zero-duration behaviour of both counters
    a_inact_restart: assert property (@(posedge core_clk) disable iff (srst) // R8
        sample_valid && !inact_q |=> inact_cnt_r == 16'h0000)
        else $error("inactivity counter not restarted");
    a_act_zero_dur: assert property (@(posedge core_clk) disable iff (srst) // R1
        sample_valid && act_q && (act_dur_r == 8'h00) && (act_cnt_r == 8'h00) |=> activity_event)
        else $error("zero activity duration did not fire at once");
    a_inact_zero_dur: assert property (@(posedge core_clk) disable iff (srst) // R4
        sample_valid && inact_q && (inact_dur == 16'h0000) && (inact_cnt_r == 16'h0000)
        |=> inactivity_event)
        else $error("zero inactivity duration did not fire at once");
    a_event_from_sample: assert property (@(posedge core_clk) disable iff (srst) // R1
        activity_event |-> $past(sample_valid))
        else $error("activity event without a sample");

    // Sticky status, set beats a same-cycle write-one clear
    assign status_nxt = (status_r & ~(we_stat ? wd[1:0] : 2'b00))
                        | {inact_fire, act_fire};

    // Mask as it stands after this edge, so irq tracks a mask write at once
    assign mask_nxt = we_mask ? wd[1:0] : mask_r;

    // Status stickiness and interrupt level
    a_act_set_wins: assert property (@(posedge core_clk) disable iff (srst)
        act_fire |=> status_r[mai_pkg::ST_ACT_BIT])
        else $error("activity status not set by event");
    a_inact_set_wins: assert property (@(posedge core_clk) disable iff (srst)
        inact_fire |=> status_r[mai_pkg::ST_INACT_BIT])
        else $error("inactivity status not set by event");
    a_status_sticky: assert property (@(posedge core_clk) disable iff (srst)
        status_r[mai_pkg::ST_INACT_BIT] && !(we_stat && wd[mai_pkg::ST_INACT_BIT])
        |=> status_r[mai_pkg::ST_INACT_BIT])
        else $error("inactivity status dropped without a clear");
    a_irq_low: assert property (@(posedge core_clk) disable iff (srst)
        !(|(status_r & mask_r)) |-> !irq)
        else $error("interrupt high with no unmasked status");

    // Bus side flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= mai_pkg::HRESP_OKAY;
        end else begin
            wr_pend_r <= wr_start;
            wr_idx_r  <= addr_idx;
            // Read data latched at address phase; no wait states needed
            if (rd_start) begin
                hrdata <= in_map ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            end
            hreadyout <= 1'b1;
            hresp     <= mai_pkg::HRESP_OKAY;
        end
    end

    // Bus answer checks; zero wait states and OKAY are promised to the master
    a_bus_ready: assert property (@(posedge core_clk) disable iff (srst)
        hreadyout)
        else $error("slave inserted a wait state");
    a_bus_okay: assert property (@(posedge core_clk) disable iff (srst)
        hresp == mai_pkg::HRESP_OKAY)
        else $error("slave gave an error response");
    a_rdata_upper_zero: assert property (@(posedge core_clk) disable iff (srst) // R8
        hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_unused_reads_zero: assert property (@(posedge core_clk) disable iff (srst) // R8
        rd_start && in_map && (addr_idx > mai_pkg::IDX_MASK) |=> hrdata == 32'h0000_0000)
        else $error("unused register read not zero");
    a_rsvd_low_bits: assert property (@(posedge core_clk) disable iff (srst) // R8
        rd_start && in_map && (addr_idx == mai_pkg::IDX_ACT_THR_L ||
        addr_idx == mai_pkg::IDX_INACT_THR_L) |=> hrdata[1:0] == 2'b00)
        else $error("threshold low reserved bits not zero");
    a_rsvd_top_bit: assert property (@(posedge core_clk) disable iff (srst) // R8
        rd_start && in_map && (addr_idx == mai_pkg::IDX_ACT_THR_H ||
        addr_idx == mai_pkg::IDX_INACT_THR_H) |=> hrdata[7] == 1'b0)
        else $error("threshold high reserved bit not zero");

    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            act_thr_h_r   <= mai_pkg::RST_BYTE[6:0];
            act_thr_l_r   <= mai_pkg::RST_BYTE[5:0];
            act_dur_r     <= mai_pkg::RST_BYTE;                       // R6
            inact_thr_h_r <= mai_pkg::RST_BYTE[6:0];                  // R6
            inact_thr_l_r <= mai_pkg::RST_BYTE[5:0];                  // R6
            inact_dur_h_r <= mai_pkg::RST_BYTE;                       // R6
            inact_dur_l_r <= mai_pkg::RST_BYTE;                       // R6
            mask_r        <= mai_pkg::RST_ST;
        end else begin
            if (we_act_h)  act_thr_h_r   <= wd[6:0];
            if (we_act_l)  act_thr_l_r   <= wd[7:2];
            if (we_adur)   act_dur_r     <= wd;
            if (we_ith_h)  inact_thr_h_r <= wd[6:0];                  // R3
            if (we_ith_l)  inact_thr_l_r <= wd[7:2];                  // R3
            if (we_idur_h) inact_dur_h_r <= wd;                       // R5
            if (we_idur_l) inact_dur_l_r <= wd;                       // R5
            if (we_mask)   mask_r        <= wd[1:0];
        end
    end

    // Writes land in the data phase edge, low byte lane only
    a_act_dur_write: assert property (@(posedge core_clk) disable iff (srst) // R1
        we_adur |=> act_dur_r == $past(hwdata[7:0]))
        else $error("activity duration write lost");
    a_thr_high_join: assert property (@(posedge core_clk) disable iff (srst) // R3
        we_ith_h |=> inact_thr[12:6] == $past(hwdata[6:0]))
        else $error("inactivity threshold high bits misplaced");
    a_dur_low_join: assert property (@(posedge core_clk) disable iff (srst) // R5
        we_idur_l |=> inact_dur[7:0] == $past(hwdata[7:0]))
        else $error("inactivity duration low byte misplaced");
    a_mask_write: assert property (@(posedge core_clk) disable iff (srst)
        we_mask |=> mask_r == $past(hwdata[1:0]))
        else $error("mask write lost");

    // Detection state, events and interrupt
    always_ff @(posedge core_clk) begin
        if (srst) begin
            act_cnt_r        <= 8'h00;
            inact_cnt_r      <= 16'h0000;
            status_r         <= mai_pkg::RST_ST;
            activity_event   <= 1'b0;
            inactivity_event <= 1'b0;
            irq              <= 1'b0;
        end else begin
            act_cnt_r        <= act_cnt_nxt;
            inact_cnt_r      <= inact_cnt_nxt;
            status_r         <= status_nxt;
            activity_event   <= act_fire;                             // R1
            inactivity_event <= inact_fire;                           // R4
            irq              <= |(status_nxt & mask_nxt);
        end
    end

    // Checks
    a_act_restart: assert property (@(posedge core_clk) disable iff (srst) // R8
        sample_valid && !act_q |=> act_cnt_r == 8'h00)
        else $error("activity counter not restarted");
    a_act_event_count: assert property (@(posedge core_clk) disable iff (srst) // R1
        activity_event |-> act_cnt_r == act_target && $past(act_cnt_r) + 8'h01 == act_target)
        else $error("activity event at wrong count");
    a_inact_event_count: assert property (@(posedge core_clk) disable iff (srst) // R4
        inactivity_event |-> inact_cnt_r == inact_target && $past(inact_q))
        else $error("inactivity event at wrong count");
    a_inact_strict_below: assert property (@(posedge core_clk) disable iff (srst) // R2
        sample_valid && (sample_x == $signed({1'b0, inact_thr})) |=> inact_cnt_r == 16'h0000)
        else $error("sample equal to threshold counted inactive");
    a_thr_low_join: assert property (@(posedge core_clk) disable iff (srst) // R3
        we_ith_l |=> inact_thr[5:0] == $past(hwdata[7:2]) && inact_thr[12:6] == $past(inact_thr_h_r))
        else $error("inactivity threshold low bits misplaced");
    a_dur_high_join: assert property (@(posedge core_clk) disable iff (srst) // R5
        we_idur_h |=> inact_dur[15:8] == $past(hwdata[7:0]) && inact_dur[7:0] == $past(inact_dur_l_r))
        else $error("inactivity duration high byte misplaced");
    a_reset_clears: assert property (@(posedge core_clk) // R6
        srst |=> act_dur_r == 8'h00 && inact_thr == 13'h0000 && inact_dur == 16'h0000)
        else $error("configuration not cleared by reset");
    a_act_above_counts: assert property (@(posedge core_clk) disable iff (srst) // R7
        sample_valid && !sample_x[13] && (sample_x > $signed({1'b0, act_thr})) |=> act_cnt_r != 8'h00)
        else $error("axis above activity threshold not counted");
    a_irq_follows: assert property (@(posedge core_clk) disable iff (srst)
        |(status_r & mask_r) |-> irq)
        else $error("interrupt low with unmasked status set");
endmodule : mai_top
`default_nettype wire

// ---- mai_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module mai_tb_top;
    // Bench drive and model state
    logic               core_clk = 1'b0;
    logic               srst = 1'b1;
    logic               hsel = 1'b0;
    logic [31:0]        haddr = '0;
    logic [1:0]         htrans = '0;
    logic               hwrite = 1'b0;
    logic [31:0]        hwdata = '0;
    logic               sample_valid = 1'b0;
    logic signed [13:0] sx = '0, sy = '0, sz = '0;
    wire logic          hreadyout, hresp, act_ev, inact_ev, irq;
    wire logic [31:0]   hrdata;
    logic [31:0]        lf = 32'h0000_840a;
    logic [7:0]         rb[7] = '{default: 8'h00};
    int                 error_cnt = 0, checked = 0, acnt = 0, icnt = 0, st = 0, mk = 0, v;

    always #2.5 core_clk = ~core_clk;

    mai_top i_mai_top (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sample_valid(sample_valid),
        .sample_x(sx), .sample_y(sy), .sample_z(sz), .activity_event(act_ev),
        .inactivity_event(inact_ev), .irq(irq));

    // Stimulus source, fixed start state
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction : rnd

    function automatic int ab(input int a);
        return (a < 0) ? -a : a;
    endfunction : ab

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // Master never assumes a latency; only the watchdog ends a stuck wait
    task automatic wait_rdy();
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask : wait_rdy

    task automatic xfer(input bit wr, input logic [7:0] idx, input logic [31:0] d,
                        output logic [31:0] rd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= mai_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        hsel   <= 1'b0;
        chk("hresp", hresp, 32'h0);
        chk("hreadyout", hreadyout, 32'h1);
    endtask : xfer

    // Write through the bus and mirror it in the model
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        xfer(1'b1, idx, d, rd);
        if (idx >= 8'h20 && idx <= 8'h26)
            rb[idx - 8'h20] = d[7:0] & ((idx == 8'h20 || idx == 8'h23) ? 8'h7f :
                                        (idx == 8'h21 || idx == 8'h24) ? 8'hfc : 8'hff);
        if (idx == mai_pkg::IDX_STATUS) st = st & ~int'(d[1:0]);
        if (idx == mai_pkg::IDX_MASK) mk = int'(d[1:0]);
        #1 chk("irq", irq, 32'((st & mk) != 0));
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx);
        logic [31:0] rd;
        xfer(1'b0, idx, 32'h0, rd);
        chk("rdata", rd, (idx >= 8'h20 && idx <= 8'h26) ? {24'h0, rb[idx - 8'h20]} :
            (idx == mai_pkg::IDX_STATUS) ? st : (idx == mai_pkg::IDX_MASK) ? mk : 0);
    endtask : rd_chk

    // One sample, then event and irq compared against the counting model
    task automatic smp(input int x, input int y, input int z);
        int  athr, ithr, ad, id;
        bit  ea, ei;
        athr = {rb[0][6:0], rb[1][7:2]};
        ithr = {rb[3][6:0], rb[4][7:2]};
        ad   = (rb[2] == 0) ? 1 : rb[2];
        id   = ({rb[5], rb[6]} == 0) ? 1 : {rb[5], rb[6]};
        @(posedge core_clk);
        sample_valid <= 1'b1;
        sx <= x[13:0];
        sy <= y[13:0];
        sz <= z[13:0];
        @(posedge core_clk);
        sample_valid <= 1'b0;
        #1;
        ea = 0;
        ei = 0;
        if (!(ab(x) > athr || ab(y) > athr || ab(z) > athr)) acnt = 0;
        else if (acnt < ad) begin acnt++; ea = (acnt == ad); end
        if (!(ab(x) < ithr && ab(y) < ithr && ab(z) < ithr)) icnt = 0;
        else if (icnt < id) begin icnt++; ei = (icnt == id); end
        st = st | {ei, ea};
        chk("activity_event", act_ev, ea);
        chk("inactivity_event", inact_ev, ei);
        chk("irq", irq, 32'((st & mk) != 0));
    endtask : smp

    // Main sequence
    initial begin
        int av[11] = '{101, 0, -101, 100, 101, -101, -8192, 101, 101, 0, 101};
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        for (int i = 0; i < 7; i++) rd_chk(mai_pkg::IDX_ACT_THR_H + 8'(i));
        rd_chk(mai_pkg::IDX_STATUS);
        wr(8'h3f, 32'hffff_ffff);
        rd_chk(8'h3f);
        $display("reset and unmapped test done");
        for (int i = 0; i < 7; i++) wr(mai_pkg::IDX_ACT_THR_H + 8'(i), rnd());
        for (int i = 0; i < 7; i++) rd_chk(mai_pkg::IDX_ACT_THR_H + 8'(i));
        $display("register test done");
        wr(8'h20, 32'h01);
        wr(8'h21, 32'h90);
        wr(8'h22, 32'h03);
        wr(8'h23, 32'h00);
        wr(8'h24, 32'h00);
        wr(mai_pkg::IDX_MASK, 32'h2);
        for (int i = 0; i < 11; i++)
            smp(i % 3 == 0 ? av[i] : 0, i % 3 == 1 ? av[i] : 0, i % 3 == 2 ? av[i] : 0);
        rd_chk(mai_pkg::IDX_STATUS);
        wr(mai_pkg::IDX_MASK, 32'h3);
        wr(mai_pkg::IDX_STATUS, 32'h1);
        $display("activity test done");
        wr(8'h20, 32'h7f);
        wr(8'h21, 32'hfc);
        wr(8'h24, 32'h28);
        wr(8'h25, 32'h01);
        wr(8'h26, 32'h02);
        for (int i = 0; i < 400; i++) begin
            v = (i == 100) ? 10 : int'(rnd() % 19) - 9;
            smp(v, (i == 50) ? -10 : int'(rnd() % 19) - 9, int'(rnd() % 19) - 9);
        end
        wr(mai_pkg::IDX_STATUS, 32'h3);
        $display("inactivity test done");
        wr(8'h20, 32'h00);
        wr(8'h21, rnd());
        wr(8'h22, rnd() % 4);
        wr(8'h24, rnd());
        wr(8'h25, 32'h00);
        wr(8'h26, rnd() % 4);
        for (int i = 0; i < 300; i++)
            smp(int'(rnd() % 64) - 32, int'(rnd() % 64) - 32, int'(rnd() % 64) - 32);
        $display("random sample test done");
        end_sim();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        end_sim();
    end
endmodule : mai_tb_top
`default_nettype wire
